//--- verilog/ucb_pkg.sv
package ucb_pkg;
  // Register byte offsets
  localparam logic [4:0] OFF_CTRL_ONE = 5'h00;
  localparam logic [4:0] OFF_CTRL_TWO = 5'h04;
  localparam logic [4:0] OFF_DIVISOR = 5'h08;
  localparam logic [4:0] OFF_DATA = 5'h0c;
  localparam logic [4:0] OFF_STATUS = 5'h10;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h18;

  // uart_control_two fields
  localparam int TX_ON_BIT = 7;
  localparam int RX_ON_BIT = 6;
  localparam int SPEED_BIT = 5;
  localparam int ADDR_DET_BIT = 4;
  localparam int WAKE_BIT = 3;
  localparam int RX_IRQ_BIT = 2;
  localparam int TX_IDLE_FLAG_IRQ_BIT = 1;
  localparam int TEMPTY_IRQ_BIT = 0;

  // First control register fields
  localparam int MASTER_BIT = 7;
  localparam int WLEN_BIT = 6;
  localparam int RX_NINTH_BIT = 1;
  localparam int TX_NINTH_BIT = 0;
  localparam logic [7:0] CTRL_ONE_WMASK = 8'hc1;

  // Status fields
  localparam int OVR_BIT = 4;
  localparam int RX_IDLE_BIT = 3;
  localparam int RX_AVAIL_BIT = 2;
  localparam int TX_IDLE_BIT = 1;
  localparam int TX_EMPTY_BIT = 0;

  // Interrupt status and mask fields
  localparam int EV_TEMPTY = 0;
  localparam int EV_TX_IDLE_FLAG = 1;
  localparam int EV_RX = 2;
  localparam int EV_WAKE = 3;
  localparam int IRQ_W = 4;

  // Values after reset
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] DIVISOR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] IRQ_RST = 4'h0;

  // Counter expiries per bit
  localparam logic [6:0] OVS_LOW = 7'h40;
  localparam logic [6:0] OVS_HIGH = 7'h10;

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} ucb_rx_state_e;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} ucb_tx_state_e;

  function automatic logic [6:0] ticks_per_bit(input logic high);
    return high ? OVS_HIGH : OVS_LOW;
  endfunction

  function automatic logic [3:0] last_bit(input logic nine);
    return nine ? 4'h8 : 4'h7;
  endfunction
endpackage

//--- verilog/ucb_baud.sv
`timescale 1ns/10ps
module ucb_baud
#(
  parameter int WIDTH = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] divisor,
  output logic tick
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  wire expired = (cnt_q == '0);

  // Reload on expiry, so the period is divisor plus one
  assign cnt_d = expired ? divisor : cnt_q - 1'b1; // RULE_17
  assign tick = expired & ~rst; // RULE_06

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= '0; // RULE_15
    else
      cnt_q <= cnt_d;
  end
endmodule

//--- verilog/ucb_tx.sv
`timescale 1ns/10ps
module ucb_tx
import ucb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [6:0] ovs,
  input wire logic nine,
  input wire logic load,
  input wire logic [8:0] load_data,
  output logic tx_line,
  output logic busy
);
  ucb_tx_state_e state_q;
  logic [8:0] shift_q;
  logic [3:0] bit_q;
  logic [6:0] tk_q;
  wire bit_end = tick & (tk_q == ovs - 7'h01);

  assign busy = (state_q != TX_IDLE);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= TX_IDLE; // RULE_01
      tk_q <= 7'h00;
      bit_q <= 4'h0;
      shift_q <= 9'h000;
      tx_line <= 1'b1;
    end
    else
    begin
      if (tick)
        tk_q <= bit_end ? 7'h00 : tk_q + 7'h01;
      unique case (state_q)
        TX_IDLE:
          if (load)
          begin
            shift_q <= load_data;
            tk_q <= 7'h00;
            tx_line <= 1'b0;
            state_q <= TX_START;
          end
        TX_START:
          if (bit_end)
          begin
            tx_line <= shift_q[0];
            shift_q <= {1'b0, shift_q[8:1]};
            bit_q <= 4'h0;
            state_q <= TX_DATA;
          end
        TX_DATA:
          if (bit_end)
          begin
            if (bit_q == last_bit(nine)) // RULE_16
            begin
              tx_line <= 1'b1;
              state_q <= TX_STOP;
            end
            else
            begin
              tx_line <= shift_q[0];
              shift_q <= {1'b0, shift_q[8:1]};
              bit_q <= bit_q + 4'h1;
            end
          end
        TX_STOP:
          if (bit_end)
            state_q <= TX_IDLE;
      endcase
    end
  end
endmodule

//--- verilog/ucb_top.sv
// Overview of operation
// RULE_01 - Clearing transmit enable aborts sending, empties transmit buffer, frees TX.
// RULE_02 - UART owns TX only while transmit enable and master enable are set.
// RULE_03 - Clearing receive enable aborts reception, empties receive buffer, frees RX.
// RULE_04 - Receiver runs and owns RX only while receive and master enables set.
// RULE_05 - Bit rate is clock over 64(N+1) low speed, 16(N+1) high speed.
// RULE_06 - Bits timed by a free-running 8-bit counter set by divisor 0..255.
// RULE_07 - Address detect: word with address bit one is kept and may interrupt.
// RULE_08 - Address detect: word with address bit zero is dropped, no interrupt.
// RULE_09 - UART clock off and wake enabled: RX falling edge requests wake-up.
// RULE_10 - No wake-up while UART clock runs or wake enable is clear.
// RULE_11 - Receive enable lets overrun or data-available setting raise request; the code also requires the receive interrupt enable.
// RULE_12 - Idle interrupt enable lets transmitter-idle setting raise request.
// RULE_13 - Empty interrupt enable lets transmit-empty setting raise request.
// RULE_14 - One data location: write sends next character, read gives last received.
// RULE_15 - Master off empties buffers, resets counter, clears enables and flags.
// RULE_16 - Word length select picks 8 or 9 bits; ninth bits in control one.
// RULE_17 - Counter reloads on expiry; 16 or 64 expiries make one bit.
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module ucb_top
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic RX_I,
  output logic TX_O,
  output logic TX_OWN,
  output logic RX_OWN,
  input wire logic UART_CLK_ON,
  output logic IRQ
);
  import ucb_pkg::*;

  // Bus slave: one wait state, answer on the second edge
  logic ack_q;
  logic [31:0] rdata_q;
  wire req = AVS_READ | AVS_WRITE;
  wire wr_acc = AVS_WRITE & ack_q & AVS_BYTEENABLE[0];
  wire rd_acc = AVS_READ & ack_q;
  wire [7:0] wd = AVS_WRITEDATA[7:0];

  wire sel_one = (AVS_ADDRESS == OFF_CTRL_ONE);
  wire sel_two = (AVS_ADDRESS == OFF_CTRL_TWO);
  wire sel_div = (AVS_ADDRESS == OFF_DIVISOR);
  wire sel_data = (AVS_ADDRESS == OFF_DATA);
  wire sel_stat = (AVS_ADDRESS == OFF_STATUS);
  wire sel_istat = (AVS_ADDRESS == OFF_IRQ_STAT);
  wire sel_imask = (AVS_ADDRESS == OFF_IRQ_MASK);

  assign AVS_WAITREQUEST = req & ~ack_q;
  assign AVS_READDATA = rdata_q;

  // Software state
  logic [7:0] ctrl_one_q;
  logic [7:0] ctrl_one_d;
  logic [7:0] ctrl_two_q;
  logic [7:0] ctrl_two_d;
  logic [7:0] divisor_q;
  logic [7:0] tx_data_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_stat_d;
  logic [IRQ_W-1:0] irq_mask_q;

  wire master_on = ctrl_one_q[MASTER_BIT];
  wire word_length_select = ctrl_one_q[WLEN_BIT];
  wire tx_ninth_bit = ctrl_one_q[TX_NINTH_BIT];
  wire transmitter_on = ctrl_two_q[TX_ON_BIT];
  wire receiver_on = ctrl_two_q[RX_ON_BIT];
  wire baud_speed_select = ctrl_two_q[SPEED_BIT];
  wire address_detect_on = ctrl_two_q[ADDR_DET_BIT];
  wire wake_on = ctrl_two_q[WAKE_BIT];
  wire receive_irq_on = ctrl_two_q[RX_IRQ_BIT];
  wire tx_idle_irq_on = ctrl_two_q[TX_IDLE_FLAG_IRQ_BIT];
  wire tx_empty_irq_on = ctrl_two_q[TEMPTY_IRQ_BIT];

  wire tx_run = transmitter_on & master_on; // RULE_02
  wire rx_run = receiver_on & master_on; // RULE_04
  wire [6:0] ovs = ticks_per_bit(baud_speed_select); // RULE_05

  wire wr_data = wr_acc & sel_data;
  wire rd_data = rd_acc & sel_data;

  // Master off drops both direction enables
  assign ctrl_one_d = (wr_acc & sel_one) ?
    ((wd & CTRL_ONE_WMASK) | (ctrl_one_q & ~CTRL_ONE_WMASK)) : ctrl_one_q;
  logic [7:0] ctrl_two_w;
  assign ctrl_two_w = (wr_acc & sel_two) ? wd : ctrl_two_q;
  assign ctrl_two_d = master_on ? ctrl_two_w
    : (ctrl_two_w & ~(8'h01 << RX_ON_BIT) & ~(8'h01 << TX_ON_BIT)); // RULE_15

  // Baud generator
  logic tick;
  ucb_baud #(.WIDTH(8)) u_baud
  (
    .clk(CLK),
    .rst(SYS_RST | ~master_on), // RULE_15
    .divisor(divisor_q),
    .tick(tick)
  );

  // Transmit side
  logic tx_empty_q;
  logic tx_idle_q;
  logic tx_run_q;
  logic tx_line;
  logic tx_busy;
  wire tx_abort = tx_run_q & ~tx_run;
  // Load only on a tick so the start bit lasts one full bit period
  wire tx_load = tx_run & ~tx_busy & ~tx_empty_q & tick; // RULE_17
  wire tx_empty_set = tx_abort | tx_load | ~master_on;
  // Writes are refused while the buffer is still full
  wire tx_take = wr_data & tx_empty_q;
  wire tx_empty_d = tx_empty_set ? 1'b1 : (tx_take ? 1'b0 : tx_empty_q);
  wire tx_idle = tx_empty_q & ~tx_busy;

  ucb_tx u_tx
  (
    .clk(CLK),
    .rst(SYS_RST | ~tx_run), // RULE_01
    .tick(tick),
    .ovs(ovs),
    .nine(word_length_select),
    .load(tx_load),
    .load_data({word_length_select & tx_ninth_bit, tx_data_q}),
    .tx_line(tx_line),
    .busy(tx_busy)
  );

  assign TX_OWN = tx_run; // RULE_02
  assign TX_O = tx_run ? tx_line : 1'b1; // RULE_01

  // Receive side
  ucb_rx_state_e rx_state_q;
  logic rx_prev_q;
  logic [6:0] rx_tk_q;
  logic [3:0] rx_bit_q;
  logic [8:0] rx_sh_q;
  logic [7:0] rx_data_q;
  logic rx_ninth_q;
  logic rx_avail_q;
  logic overrun_q;

  wire rx_fall = rx_prev_q & ~RX_I;
  wire rx_bit_end = tick & (rx_tk_q == ovs - 7'h01);
  wire rx_half = tick & (rx_tk_q == (ovs >> 1) - 7'h01);
  wire frame_done = (rx_state_q == RX_STOP) & rx_bit_end;
  wire [8:0] rx_word = word_length_select ? rx_sh_q
    : {1'b0, rx_sh_q[8:1]}; // RULE_16
  wire addr_bit = word_length_select ? rx_word[8] : rx_word[7];
  wire rx_keep = ~address_detect_on | addr_bit; // RULE_07 RULE_08
  wire rx_store = frame_done & rx_keep & (~rx_avail_q | rd_data);
  wire ovr_set = frame_done & rx_keep & rx_avail_q & ~rd_data;
  // Set wins over the clearing read
  wire rx_avail_d = ~rx_run ? 1'b0
    : (rx_store ? 1'b1 : (rd_data ? 1'b0 : rx_avail_q)); // RULE_03
  wire overrun_d = ~rx_run ? 1'b0
    : (ovr_set ? 1'b1 : (rd_data ? 1'b0 : overrun_q)); // RULE_15

  assign RX_OWN = rx_run; // RULE_04

  always_ff @(posedge CLK)
  begin
    if (SYS_RST | ~rx_run)
    begin
      rx_state_q <= RX_IDLE; // RULE_03
      rx_tk_q <= 7'h00;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
    end
    else
    begin
      if (tick)
        rx_tk_q <= rx_bit_end ? 7'h00 : rx_tk_q + 7'h01;
      unique case (rx_state_q)
        RX_IDLE:
          if (rx_fall)
          begin
            rx_tk_q <= 7'h00;
            rx_state_q <= RX_START;
          end
        RX_START:
          if (rx_half)
          begin
            rx_tk_q <= 7'h00;
            rx_bit_q <= 4'h0;
            rx_state_q <= RX_I ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (rx_bit_end)
          begin
            rx_sh_q <= {RX_I, rx_sh_q[8:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == last_bit(word_length_select))
              rx_state_q <= RX_STOP;
          end
        RX_STOP:
          if (rx_bit_end)
            rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // Events into the request flags
  wire ev_rx = rx_store | ovr_set;
  wire ev_tempty = tx_empty_d & ~tx_empty_q;
  wire ev_tx_idle_flag = tx_idle & ~tx_idle_q;
  wire ev_wake = ~UART_CLK_ON & wake_on & rx_fall; // RULE_09 RULE_10
  logic [IRQ_W-1:0] irq_set;
  assign irq_set[EV_RX] = receive_irq_on & ev_rx; // RULE_11
  assign irq_set[EV_TX_IDLE_FLAG] = tx_idle_irq_on & ev_tx_idle_flag; // RULE_12
  assign irq_set[EV_TEMPTY] = tx_empty_irq_on & ev_tempty; // RULE_13
  assign irq_set[EV_WAKE] = ev_wake; // RULE_09
  wire [IRQ_W-1:0] irq_clr = (wr_acc & sel_istat) ? wd[IRQ_W-1:0]
    : {IRQ_W{1'b0}};
  assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
  assign IRQ = |(irq_stat_q & irq_mask_q);

  // Read multiplexer
  wire [7:0] rd_one = (ctrl_one_q & CTRL_ONE_WMASK)
    | ({7'h00, rx_ninth_q} << RX_NINTH_BIT);
  wire [7:0] rd_stat = ({7'h00, overrun_q} << OVR_BIT)
    | ({7'h00, rx_state_q == RX_IDLE} << RX_IDLE_BIT)
    | ({7'h00, rx_avail_q} << RX_AVAIL_BIT)
    | ({7'h00, tx_idle} << TX_IDLE_BIT)
    | ({7'h00, tx_empty_q} << TX_EMPTY_BIT);
  wire [7:0] rd_mux =
    sel_one ? rd_one :
    sel_two ? ctrl_two_q :
    sel_div ? divisor_q :
    sel_data ? rx_data_q : // RULE_14
    sel_stat ? rd_stat :
    sel_istat ? {4'h0, irq_stat_q} :
    sel_imask ? {4'h0, irq_mask_q} :
    8'h00;

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      if (AVS_READ & ~ack_q)
        rdata_q <= {24'h00_0000, rd_mux};
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      ctrl_one_q <= CTRL_ONE_RST;
      ctrl_two_q <= CTRL_TWO_RST;
      divisor_q <= DIVISOR_RST;
      irq_stat_q <= IRQ_RST;
      irq_mask_q <= IRQ_RST;
    end
    else
    begin
      ctrl_one_q <= ctrl_one_d;
      ctrl_two_q <= ctrl_two_d;
      if (wr_acc & sel_div)
        divisor_q <= wd; // RULE_06
      irq_stat_q <= irq_stat_d;
      if (wr_acc & sel_imask)
        irq_mask_q <= wd[IRQ_W-1:0];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      tx_data_q <= DATA_RST;
      rx_data_q <= DATA_RST;
      rx_ninth_q <= 1'b0;
    end
    else
    begin
      if (tx_take)
        tx_data_q <= wd; // RULE_14
      if (rx_store)
      begin
        rx_data_q <= rx_word[7:0];
        rx_ninth_q <= rx_word[8]; // RULE_16
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      tx_empty_q <= 1'b1;
      tx_idle_q <= 1'b1;
      tx_run_q <= 1'b0;
      rx_avail_q <= 1'b0;
      overrun_q <= 1'b0;
      rx_prev_q <= 1'b1;
    end
    else
    begin
      tx_empty_q <= tx_empty_d; // RULE_01
      tx_idle_q <= tx_idle;
      tx_run_q <= tx_run;
      rx_avail_q <= rx_avail_d;
      overrun_q <= overrun_d;
      rx_prev_q <= RX_I;
    end
  end
endmodule

//--- test/ucb_checker.sv
`timescale 1ns/10ps
module ucb_checker
import ucb_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic RX_I,
  input wire logic TX_O,
  input wire logic TX_OWN,
  input wire logic RX_OWN,
  input wire logic UART_CLK_ON,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  wire acc_w = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  wire ctl1_w = acc_w && AVS_ADDRESS == OFF_CTRL_ONE;
  wire ctl2_w = acc_w && AVS_ADDRESS == OFF_CTRL_TWO;
  wire clr_w = acc_w && AVS_ADDRESS == OFF_IRQ_STAT;
  sequence s_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_ack;
    (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST;
  endsequence
  sequence s_start;
    $fell(TX_O) && TX_OWN;
  endsequence
  property p_one_wait;
    s_req |=> s_ack;
  endproperty
  property p_tx_free;
    !TX_OWN |-> TX_O;
  endproperty
  property p_tx_off;
    ctl2_w && !AVS_WRITEDATA[TX_ON_BIT] |=> !TX_OWN;
  endproperty
  property p_rx_off;
    ctl2_w && !AVS_WRITEDATA[RX_ON_BIT] |=> !RX_OWN;
  endproperty
  property p_master_off;
    ctl1_w && !AVS_WRITEDATA[MASTER_BIT] |=> !TX_OWN && !RX_OWN;
  endproperty
  property p_start_len;
    s_start |-> (!TX_O || !TX_OWN) [*8];
  endproperty
  property p_rd_wide;
    s_ack and AVS_READ |-> AVS_READDATA[31:8] == 24'h00_0000;
  endproperty
  property p_irq_clr;
    clr_w && AVS_WRITEDATA[3:0] == 4'hf |=> !IRQ;
  endproperty
  property p_no_wake;
    $fell(RX_I) && UART_CLK_ON && !IRQ && !AVS_WRITE |=> !IRQ;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus wait not one cycle");
  a_tx_free: assert property (p_tx_free)
    else $error("tx line driven while released");
  a_tx_off: assert property (p_tx_off)
    else $error("tx still owned");
  a_rx_off: assert property (p_rx_off)
    else $error("rx still owned");
  a_master_off: assert property (p_master_off)
    else $error("pins owned with master off");
  a_start_len: assert property (p_start_len)
    else $error("start bit too short");
  a_rd_wide: assert property (p_rd_wide)
    else $error("upper read data not zero");
  a_irq_clr: assert property (p_irq_clr)
    else $error("irq not cleared");
  a_no_wake: assert property (p_no_wake)
    else $error("wake with clock running");
endmodule

bind ucb_top ucb_checker i_chk(.CLK(CLK), .SYS_RST(SYS_RST),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .RX_I(RX_I), .TX_O(TX_O), .TX_OWN(TX_OWN), .RX_OWN(RX_OWN),
  .UART_CLK_ON(UART_CLK_ON), .IRQ(IRQ));

//--- test/ucb_station.sv
`timescale 1ns/10ps
module ucb_station
(
  input wire logic clk,
  input wire logic tx_line,
  output logic rx_line
);
  initial rx_line = 1'b1;
  task automatic send_word(input logic [8:0] w, input int nb,
    input int per);
    int i;
    @(posedge clk);
    rx_line <= 1'b0;
    repeat (per) @(posedge clk);
    for (i = 0; i < nb; i++)
    begin
      rx_line <= w[i];
      repeat (per) @(posedge clk);
    end
    rx_line <= 1'b1;
    repeat (per) @(posedge clk);
  endtask
  // Bit 0 must be one so the start length is measurable
  task automatic get_word(output logic [8:0] w, input int nb,
    input int per, output int sl);
    int i;
    w = 9'h000;
    sl = 0;
    while (tx_line !== 1'b0) @(posedge clk);
    while (tx_line === 1'b0)
    begin
      sl++;
      @(posedge clk);
    end
    repeat (per / 2) @(posedge clk);
    for (i = 0; i < nb; i++)
    begin
      w[i] = tx_line;
      repeat (per) @(posedge clk);
    end
  endtask
endmodule

//--- test/uart_control_baud_gen_test.sv
`timescale 1ns/10ps
module uart_control_baud_gen_test;
  import ucb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] be = 4'hf;
  logic clk_on = 1'b1;
  logic [31:0] rdata;
  logic wait_r, rx_l, tx_l, tx_own, rx_own, irq;
  int err_count = 0;
  int samples_checked = 0;
  logic [7:0] v;
  logic [8:0] w;
  int sl;
  always #50 clk = ~clk;
  ucb_top i_dut(.CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_r), .RX_I(rx_l), .TX_O(tx_l),
    .TX_OWN(tx_own), .RX_OWN(rx_own), .UART_CLK_ON(clk_on),
    .IRQ(irq));
  ucb_station i_peer(.clk(clk), .tx_line(tx_l), .rx_line(rx_l));
  task automatic chk(input string n, input logic [8:0] e,
    input logic [8:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd <= {24'h00_0000, d};
    wr <= 1'b1;
    @(posedge clk);
    while (wait_r) @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string n, input logic [4:0] a,
    input logic [7:0] e);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    while (wait_r) @(posedge clk);
    v = rdata[7:0];
    rd <= 1'b0;
    chk(n, {1'b0, e}, {1'b0, v});
  endtask
  task automatic pins(input logic t, input logic r);
    @(negedge clk);
    chk("tx_own", {8'h00, t}, {8'h00, tx_own});
    chk("rx_own", {8'h00, r}, {8'h00, rx_own});
  endtask
  task automatic wait_irq(input logic e);
    int i;
    for (i = 0; i < 2000 && irq !== e; i++) @(posedge clk);
    chk("irq", {8'h00, e}, {8'h00, irq});
  endtask
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_chk("ctrl_two", OFF_CTRL_TWO, 8'h00);
    rd_chk("unmapped", 5'h1c, 8'h00);
    bus_wr(OFF_DIVISOR, 8'h01);
    bus_wr(OFF_CTRL_ONE, 8'h80);
    pins(1'b0, 1'b0);
    bus_wr(OFF_IRQ_MASK, 8'h0c);
    bus_wr(OFF_CTRL_TWO, 8'h80);
    pins(1'b1, 1'b0);
    bus_wr(OFF_DATA, 8'h5b);
    i_peer.get_word(w, 8, 128, sl);
    chk("tx_word", 9'h05b, w);
    chk("bit_low", 9'd128, sl[8:0]);
    bus_wr(OFF_CTRL_TWO, 8'ha0);
    bus_wr(OFF_CTRL_ONE, 8'hc1);
    bus_wr(OFF_DATA, 8'h13);
    i_peer.get_word(w, 9, 32, sl);
    chk("tx_nine", 9'h113, w);
    chk("bit_high", 9'd32, sl[8:0]);
    bus_wr(OFF_DATA, 8'h01);
    repeat (40) @(posedge clk);
    bus_wr(OFF_IRQ_MASK, 8'h03);
    bus_wr(OFF_CTRL_TWO, 8'ha3);
    wait_irq(1'b1);
    rd_chk("tx_idle_flag", OFF_IRQ_STAT, 8'h02);
    bus_wr(OFF_DATA, 8'h01);
    repeat (4) @(posedge clk);
    rd_chk("tempty", OFF_IRQ_STAT, 8'h03);
    bus_wr(OFF_IRQ_MASK, 8'h0c);
    bus_wr(OFF_CTRL_TWO, 8'h00);
    pins(1'b0, 1'b0);
    chk("tx_idle", 9'h001, {8'h00, tx_l});
    $display("transmit done");
    bus_wr(OFF_CTRL_ONE, 8'h80);
    bus_wr(OFF_IRQ_STAT, 8'h0f);
    bus_wr(OFF_CTRL_TWO, 8'h64);
    pins(1'b0, 1'b1);
    i_peer.send_word(9'h03c, 8, 32);
    wait_irq(1'b1);
    rd_chk("irq_stat", OFF_IRQ_STAT, 8'h04);
    rd_chk("rx_data", OFF_DATA, 8'h3c);
    bus_wr(OFF_IRQ_STAT, 8'h0f);
    wait_irq(1'b0);
    bus_wr(OFF_CTRL_TWO, 8'h74);
    i_peer.send_word(9'h012, 8, 32);
    rd_chk("dropped", OFF_IRQ_STAT, 8'h00);
    i_peer.send_word(9'h092, 8, 32);
    wait_irq(1'b1);
    rd_chk("addr_word", OFF_DATA, 8'h92);
    bus_wr(OFF_IRQ_STAT, 8'h0f);
    $display("receive done");
    bus_wr(OFF_CTRL_TWO, 8'h08);
    clk_on <= 1'b0;
    i_peer.send_word(9'h0ff, 8, 32);
    wait_irq(1'b1);
    rd_chk("wake", OFF_IRQ_STAT, 8'h08);
    bus_wr(OFF_IRQ_STAT, 8'h0f);
    bus_wr(OFF_CTRL_TWO, 8'h00);
    i_peer.send_word(9'h0ff, 8, 32);
    rd_chk("no_wake", OFF_IRQ_STAT, 8'h00);
    bus_wr(OFF_CTRL_TWO, 8'h08);
    clk_on <= 1'b1;
    i_peer.send_word(9'h0ff, 8, 32);
    rd_chk("clk_runs", OFF_IRQ_STAT, 8'h00);
    $display("wake done");
    bus_wr(OFF_CTRL_TWO, 8'hc0);
    bus_wr(OFF_CTRL_ONE, 8'h00);
    pins(1'b0, 1'b0);
    rd_chk("forced", OFF_CTRL_TWO, 8'h00);
    rd_chk("status", OFF_STATUS, 8'h0b);
    $display("master off done");
    give_verdict();
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    err_count++;
    $display("[FAIL] watchdog exp finish got hang");
    give_verdict();
  end
endmodule
